//--- hdl/aqs_divider.sv
// Programmable enable-pulse divider used for the sample and trigger timebases
`timescale 1ns/100ps
module aqs_divider #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         srst,
	// Control
	input  wire logic         src_en,
	input  wire logic         div_en,
	input  wire logic [W-1:0] div_val,
	// Output
	output logic              tick
);
	logic [W-1:0] cnt;

	// Counts source pulses; emits one every div_val+1 pulses, or every pulse when bypassed
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt  <= '0;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (src_en) begin
				if (!div_en || cnt >= div_val) begin
					cnt  <= '0;
					tick <= 1'b1;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	end
endmodule // aqs_divider

//--- hdl/aqs_fifo.sv
// Sample FIFO holding 16-bit results, read out as packed 32-bit words
`timescale 1ns/100ps
module aqs_fifo #(
	parameter int DEPTH = 8192,
	parameter int W     = 16
) (
	// Clock and reset
	input  wire logic           core_clk,
	input  wire logic           srst,
	input  wire logic           clear,
	// Write side
	input  wire logic           wr_en,
	input  wire logic [W-1:0]   wr_data,
	// Read side, two samples per pop
	input  wire logic           rd_en,
	output logic [2*W-1:0]      rd_word,
	// Occupancy
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic          do_rd;

	assign do_rd = rd_en && level >= 2;

	// Storage array
	always_ff @(posedge core_clk) begin
		if (wr_en && level < DEPTH)
			mem[wp] <= wr_data;
	end

	// Earlier sample lands in the lower half-word; the reader registers it
	assign rd_word = {mem[rp + 1'b1], mem[rp]};

	// Pointers and occupancy
	always_ff @(posedge core_clk) begin
		if (srst || clear) begin
			wp    <= '0;
			rp    <= '0;
			level <= '0;
		end else begin
			if (wr_en && level < DEPTH)
				wp <= wp + 1'b1;
			if (do_rd)
				rp <= rp + 2'd2;
			level <= level + (AW+1)'(wr_en && level < DEPTH) - (do_rd ? (AW+1)'(2) : '0);
		end
	end
endmodule // aqs_fifo

//--- hdl/aqs_pkg.sv
// Package with register map, field layout, widths and enumerations of the acquisition sequencer
package aqs_pkg;
	// Register word addresses (byte addresses, one 32-bit word each)
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_COUNT     = 8'h04;
	localparam logic [7:0] REG_CLKDIV    = 8'h08;
	localparam logic [7:0] REG_TRIGDIV   = 8'h0C;
	localparam logic [7:0] REG_SYNTH     = 8'h10;
	localparam logic [7:0] REG_DAC       = 8'h14;
	localparam logic [7:0] REG_STATUS    = 8'h18;
	localparam logic [7:0] REG_FIFO      = 8'h1C;
	localparam logic [7:0] REG_CHAN      = 8'h20;
	// Control register field positions
	localparam int CTL_RUN     = 0;
	localparam int CTL_CLKSRC  = 1;  // 2 bits
	localparam int CTL_DIVEN   = 3;
	localparam int CTL_TRIGSRC = 4;  // 2 bits
	localparam int CTL_MODE    = 6;  // 2 bits
	localparam int CTL_PRETRIG = 8;
	localparam int CTL_MARKEN  = 9;
	localparam int CTL_BIPOLAR = 10;
	localparam int CTL_DACTRIG = 11;
	localparam int CTL_IRQSRC  = 12; // 2 bits
	localparam int CTL_IOSPACE = 14;
	localparam int CTL_AUTOINC = 15;
	localparam int CTL_W       = 16;
	localparam logic [CTL_W-1:0] CTL_RESET = 16'h0000;
	// Status register field positions
	localparam int ST_HALF  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_XFER  = 2;
	localparam int ST_EMPTY = 3;
	localparam int ST_FULL  = 4;
	localparam int ST_ARMED = 5;
	localparam int ST_MODID = 8;     // 4 bits
	// Widths and sizes
	localparam int SAMP_W     = 16;
	localparam int CNT_W      = 24;
	localparam int CLKDIV_W   = 16;
	localparam int TRIGDIV_W  = 32;
	localparam int SYNTH_W    = 16;
	localparam int DAC_W      = 12;
	localparam int MODID_W    = 4;
	localparam int FIFO_DEPTH = 8192;
	localparam logic [3:0] MODID_16BIT = 4'hF; // Module code of a 16-bit converter
	// Sources, modes and states
	typedef enum logic [1:0] {CLK_SYNTH = 2'b00, CLK_X10 = 2'b01, CLK_X20 = 2'b10,
		CLK_EXT = 2'b11} aqs_clksrc_e;
	typedef enum logic [1:0] {TRG_COMP = 2'b00, TRG_INT = 2'b01, TRG_EXT = 2'b10,
		TRG_NONE = 2'b11} aqs_trgsrc_e;
	typedef enum logic [1:0] {MD_SINGLE = 2'b00, MD_REPEAT = 2'b01, MD_FOREVER = 2'b10,
		MD_RSVD = 2'b11} aqs_mode_e;
	typedef enum logic [1:0] {IRQ_HALF = 2'b00, IRQ_DONE = 2'b01, IRQ_XFER = 2'b10,
		IRQ_OFF = 2'b11} aqs_irqsrc_e;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_WAIT = 2'b01, ST_RUN = 2'b10,
		ST_PRE = 2'b11} aqs_state_e;
endpackage

//--- hdl/aqs_sequencer.sv
// Acquisition sequencer: clocks, triggers, frame counting, marker tagging and sample FIFO
//
// Behaviour
// - Results right-justified; unipolar straight binary, bipolar sign-extended to bit 15.
// - Sample clock from synthesizer, 10 MHz, 20 MHz or external; 16-stage divider.
// - Synthesizer tick feeds the binary divider; rate set by synthesizer register.
// - Internal trigger is the 10 MHz timebase divided by a 32-stage counter.
// - Trigger from comparator, internal divider or external input; DAC sets trip level.
// - Modes: single frame, frame per trigger, or run forever without counter.
// - Frame length from 24-bit counter, 1 to 16,777,216 samples.
// - Marker enabled: marker forces stored bit 15 high in the next sample, and in each sample while it stays high.
// - Pretrigger: keep sampling, hold down-counter until external trigger.
// - Samples buffered in an 8192-entry FIFO.
// - One interrupt, source chosen among half full, frame complete, transfer done.
// - Host transfers are 32 bits wide, I/O or memory space selectable.
// - A 4-bit switch setting identifies the fitted converter module.
// - Sampling runs at programmed rate regardless of host while FIFO has room.
// - 12-bit straight binary analog output, general output or trigger threshold.
// - Each FIFO word packs two samples, earlier one in the low half.
// - Channel sequence increments and wraps to zero after highest enabled channel.
// - Marker tagging unavailable when a 16-bit converter module is fitted.
`timescale 1ns/100ps
module aqs_sequencer
	import aqs_pkg::*;
#(
	parameter int ADC_BITS   = 12,
	parameter int FIFO_DEPTH_P = FIFO_DEPTH,
	parameter int CH_W       = 4
) (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                srst,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	// Clock source enables, one-cycle pulses
	input  wire logic                synth_tick,
	input  wire logic                xtal10_tick,
	input  wire logic                xtal20_tick,
	input  wire logic                ext_clk_tick,
	// Trigger and marker inputs
	input  wire logic                comp_trip,
	input  wire logic                ext_trig,
	input  wire logic                marker,
	// Converter interface
	input  wire logic [15:0]         adc_data,
	input  wire logic [MODID_W-1:0]  module_id_sw,
	output logic                     adc_start,
	output logic [CH_W-1:0]          adc_chan,
	// Analog output and synthesizer setting
	output logic [DAC_W-1:0]         dac_code,
	output logic                     dac_is_threshold,
	output logic [SYNTH_W-1:0]       synth_setting,
	// Host side
	input  wire logic                xfer_done,
	output logic                     io_space,
	output logic                     host_irq
);
	localparam int LW = $clog2(FIFO_DEPTH_P) + 1;

	logic [CTL_W-1:0]     ctrl;
	logic [CNT_W-1:0]     count_load;
	logic [CLKDIV_W-1:0]  clkdiv;
	logic [TRIGDIV_W-1:0] trigdiv;
	logic [CH_W-1:0]      chan_top;
	logic [CNT_W-1:0]     remain;
	logic                 frame_complete_flag;
	logic                 xfer_flag;
	logic                 half_flag;
	logic                 mark_pend;
	aqs_state_e           state;
	logic                 src_tick;
	logic                 samp_tick;
	logic                 trig_tick;
	logic                 trig_ev;
	logic                 arm;
	logic                 sampling;
	logic                 take;
	logic [15:0]          samp_word;
	logic [31:0]          fifo_word;
	logic [LW-1:0]        fifo_level;
	logic                 fifo_pop;
	logic                 fifo_clr;
	logic                 mark_ok;

	// Clock source select ahead of the binary divider
	always_comb begin
		case (aqs_clksrc_e'(ctrl[CTL_CLKSRC +: 2]))
			CLK_SYNTH: src_tick = synth_tick;
			CLK_X10:   src_tick = xtal10_tick;
			CLK_X20:   src_tick = xtal20_tick;
			CLK_EXT:   src_tick = ext_clk_tick;
			default:   src_tick = 1'b0;
		endcase
	end

	aqs_divider #(.W(CLKDIV_W)) u_sampdiv (
		.core_clk (core_clk),
		.srst     (srst),
		.src_en   (src_tick),
		.div_en   (ctrl[CTL_DIVEN]),
		.div_val  (clkdiv),
		.tick     (samp_tick)
	);

	aqs_divider #(.W(TRIGDIV_W)) u_trigdiv (
		.core_clk (core_clk),
		.srst     (srst),
		.src_en   (xtal10_tick),
		.div_en   (1'b1),
		.div_val  (trigdiv),
		.tick     (trig_tick)
	);

	// Trigger select; pretrigger only reacts to the external input
	always_comb begin
		case (aqs_trgsrc_e'(ctrl[CTL_TRIGSRC +: 2]))
			TRG_COMP: trig_ev = comp_trip && ctrl[CTL_DACTRIG];
			TRG_INT:  trig_ev = trig_tick;
			TRG_EXT:  trig_ev = ext_trig;
			default:  trig_ev = 1'b0;
		endcase
		if (ctrl[CTL_PRETRIG])
			trig_ev = ext_trig;
	end

	assign arm      = reg_wr && reg_addr == REG_COUNT;
	assign sampling = state == ST_RUN || state == ST_PRE;
	// Sampling never waits on the host; a full FIFO simply drops the sample
	assign take     = sampling && samp_tick;
	assign mark_ok  = ctrl[CTL_MARKEN] && module_id_sw != MODID_16BIT;
	assign fifo_pop = reg_rd && reg_addr == REG_FIFO;
	assign fifo_clr = reg_rd && reg_addr == REG_CHAN;

	// Right-justify and sign-extend, then tag bit 15 with the marker
	always_comb begin
		samp_word = 16'h0000;
		samp_word[ADC_BITS-1:0] = adc_data[ADC_BITS-1:0];
		if (ctrl[CTL_BIPOLAR])
			samp_word[15:ADC_BITS] = {(16-ADC_BITS){adc_data[ADC_BITS-1]}};
		if (mark_ok && (mark_pend || marker))
			samp_word[15] = 1'b1;
	end

	// Marker may be shorter than a sample period; hold it until the next sample
	always_ff @(posedge core_clk) begin
		if (srst)
			mark_pend <= 1'b0;
		else if (take)
			mark_pend <= 1'b0;
		else if (marker && sampling)
			mark_pend <= 1'b1; // A marker while stopped must not tag a later frame
	end

	aqs_fifo #(.DEPTH(FIFO_DEPTH_P), .W(SAMP_W)) u_fifo (
		.core_clk (core_clk),
		.srst     (srst),
		.clear    (fifo_clr),
		.wr_en    (take),
		.wr_data  (samp_word),
		.rd_en    (fifo_pop),
		.rd_word  (fifo_word),
		.level    (fifo_level)
	);

	// Frame state machine with 24-bit down-counter
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state  <= ST_IDLE;
			remain <= '0;
		end else if (!ctrl[CTL_RUN]) begin
			state <= ST_IDLE;
		end else if (arm) begin
			remain <= reg_wdata[CNT_W-1:0];
			state  <= ctrl[CTL_PRETRIG] ? ST_PRE : ST_WAIT;
		end else begin
			case (state)
				ST_IDLE: ;
				ST_WAIT: if (trig_ev)
					state <= ST_RUN;
				ST_PRE: if (trig_ev)
					state <= ST_RUN;
				ST_RUN: begin
					if (take && aqs_mode_e'(ctrl[CTL_MODE +: 2]) != MD_FOREVER) begin
						// Zero loaded means 2^24 samples
						remain <= remain - 1'b1;
						if (remain == 24'h000001) begin
							remain <= count_load;
							state  <= aqs_mode_e'(ctrl[CTL_MODE +: 2]) == MD_REPEAT ?
								ST_WAIT : ST_IDLE;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Converter start and channel sequencing
	always_ff @(posedge core_clk) begin
		if (srst) begin
			adc_start <= 1'b0;
			adc_chan  <= '0;
		end else begin
			adc_start <= take;
			if (reg_wr && reg_addr == REG_CHAN)
				adc_chan <= '0;
			else if (take && ctrl[CTL_AUTOINC])
				adc_chan <= adc_chan >= chan_top ? '0 : adc_chan + 1'b1;
		end
	end

	// Status flags; a set in the clearing cycle wins
	always_ff @(posedge core_clk) begin
		if (srst) begin
			frame_complete_flag <= 1'b0;
			xfer_flag           <= 1'b0;
			half_flag           <= 1'b0;
		end else begin
			half_flag <= fifo_level >= LW'(FIFO_DEPTH_P / 2);
			if (state == ST_RUN && take && remain == 24'h000001 &&
				aqs_mode_e'(ctrl[CTL_MODE +: 2]) != MD_FOREVER)
				frame_complete_flag <= 1'b1;
			else if (arm)
				frame_complete_flag <= 1'b0;
			if (xfer_done)
				xfer_flag <= 1'b1;
			else if (reg_rd && reg_addr == REG_STATUS)
				xfer_flag <= 1'b0;
		end
	end

	// Interrupt source select
	always_ff @(posedge core_clk) begin
		if (srst)
			host_irq <= 1'b0;
		else
			case (aqs_irqsrc_e'(ctrl[CTL_IRQSRC +: 2]))
				IRQ_HALF: host_irq <= half_flag;
				IRQ_DONE: host_irq <= frame_complete_flag;
				IRQ_XFER: host_irq <= xfer_flag;
				default:  host_irq <= 1'b0;
			endcase
	end

	// Register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl       <= CTL_RESET;
			count_load <= '0;
			clkdiv     <= '0;
			trigdiv    <= '0;
			chan_top   <= '0;
			dac_code   <= '0;
			synth_setting <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CTRL:    ctrl       <= reg_wdata[CTL_W-1:0];
				REG_COUNT:   count_load <= reg_wdata[CNT_W-1:0];
				REG_CLKDIV:  clkdiv     <= reg_wdata[CLKDIV_W-1:0];
				REG_TRIGDIV: trigdiv    <= reg_wdata;
				REG_SYNTH:   synth_setting <= reg_wdata[SYNTH_W-1:0];
				REG_DAC:     dac_code   <= reg_wdata[DAC_W-1:0];
				REG_CHAN:    chan_top   <= reg_wdata[CH_W-1:0];
				default: ;
			endcase
		end
	end

	// Registered pin copies of control bits
	always_ff @(posedge core_clk) begin
		if (srst) begin
			io_space         <= 1'b0;
			dac_is_threshold <= 1'b0;
		end else begin
			io_space         <= ctrl[CTL_IOSPACE];
			dac_is_threshold <= ctrl[CTL_DACTRIG];
		end
	end

	// Register reads, data in the following cycle, all from one flop
	logic [31:0] rd_q;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rd_q <= '0;
		end else begin
			rd_q <= '0;
			if (reg_rd)
				case (reg_addr)
					REG_CTRL:    rd_q <= 32'(ctrl);
					REG_COUNT:   rd_q <= 32'(remain);
					REG_CLKDIV:  rd_q <= 32'(clkdiv);
					REG_TRIGDIV: rd_q <= trigdiv;
					REG_SYNTH:   rd_q <= 32'(synth_setting);
					REG_DAC:     rd_q <= 32'(dac_code);
					REG_CHAN:    rd_q <= 32'(chan_top);
					REG_FIFO:    rd_q <= fifo_level >= LW'(2) ? fifo_word : '0;
					REG_STATUS: begin
						rd_q[ST_HALF]  <= half_flag;
						rd_q[ST_DONE]  <= frame_complete_flag;
						rd_q[ST_XFER]  <= xfer_flag;
						rd_q[ST_EMPTY] <= fifo_level == '0;
						rd_q[ST_FULL]  <= fifo_level == LW'(FIFO_DEPTH_P);
						rd_q[ST_ARMED] <= state != ST_IDLE;
						rd_q[ST_MODID +: MODID_W] <= module_id_sw;
					end
					default: rd_q <= '0;
				endcase
		end
	end
	// The 32-bit word on the bus is a single register path, packed by the FIFO
	assign reg_rdata = rd_q;
endmodule // aqs_sequencer

//--- verif/aqs_conv_model.sv
// Converter and crystal oscillator model facing the sequencer
`timescale 1ns/100ps
module aqs_conv_model (
	// Clock and reset
	input wire logic         core_clk,
	input wire logic         srst,
	// Converter
	input wire logic         adc_start,
	input wire logic [15:0]  base,
	output logic [15:0]      adc_data,
	// Oscillator enables
	output logic             xtal10_tick,
	output logic             xtal20_tick
);
	logic [1:0] ph;
	logic [3:0] cnt;

	// Oscillator phase; 10 MHz is every fourth cycle, 20 MHz every second
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ph <= 2'h0;
		end else begin
			ph <= ph + 2'h1;
		end
	end
	assign xtal10_tick = (ph == 2'h3);
	assign xtal20_tick = ph[0];

	// Code steps after each conversion, so sample order shows in the data
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt <= 4'h0;
		end else if (adc_start) begin
			cnt <= cnt + 4'h1;
		end
	end
	assign adc_data = base + {12'h000, cnt};
endmodule // aqs_conv_model

//--- verif/aqs_seq_monitor.sv
// Port-level checker of the acquisition sequencer
`timescale 1ns/100ps
module aqs_seq_monitor
	import aqs_pkg::*;
#(
	parameter int CH_W = 4
) (
	// Clock and reset
	input wire logic                core_clk,
	input wire logic                srst,
	// Register port
	input wire logic [7:0]          reg_addr,
	input wire logic [31:0]         reg_wdata,
	input wire logic                reg_wr,
	input wire logic                reg_rd,
	input wire logic [31:0]         reg_rdata,
	// Device side
	input wire logic [MODID_W-1:0]  module_id_sw,
	input wire logic                adc_start,
	input wire logic [CH_W-1:0]     adc_chan,
	input wire logic [DAC_W-1:0]    dac_code,
	input wire logic                dac_is_threshold,
	input wire logic [SYNTH_W-1:0]  synth_setting,
	input wire logic                io_space,
	input wire logic                host_irq
);
	logic [CTL_W-1:0] ctl;
	logic [CH_W-1:0]  chan_top;
	logic [3:0]       idle_cnt;

	// Shadow of control and channel writes, so checks know the mode
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctl      <= CTL_RESET;
			chan_top <= '0;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ctl <= reg_wdata[CTL_W-1:0];
		end else if (reg_wr && reg_addr == REG_CHAN) begin
			chan_top <= reg_wdata[CH_W-1:0];
		end
	end

	// Cycles since run went low; saturates so it never wraps back
	always_ff @(posedge core_clk) begin
		if (srst || ctl[CTL_RUN]) begin
			idle_cnt <= 4'h0;
		end else if (idle_cnt != 4'hF) begin
			idle_cnt <= idle_cnt + 4'h1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence s_ctrl_wr;
		reg_wr && reg_addr == REG_CTRL;
	endsequence
	sequence s_status_rd;
		reg_rd && reg_addr == REG_STATUS;
	endsequence

	chk_io_space: assert property (
		s_ctrl_wr |-> ##2 io_space == $past(reg_wdata[CTL_IOSPACE], 2))
		else $error("io space select not taken from control");
	chk_thresh_sel: assert property (
		s_ctrl_wr |-> ##2 dac_is_threshold == $past(reg_wdata[CTL_DACTRIG], 2))
		else $error("analog output role not taken from control");
	chk_dac_code: assert property (
		reg_wr && reg_addr == REG_DAC |=> dac_code == $past(reg_wdata[DAC_W-1:0]))
		else $error("analog output code wrong");
	chk_synth_set: assert property (
		reg_wr && reg_addr == REG_SYNTH |=> synth_setting == $past(reg_wdata[SYNTH_W-1:0]))
		else $error("synthesizer setting wrong");
	chk_module_id: assert property (
		s_status_rd |=> reg_rdata[ST_MODID +: MODID_W] == $past(module_id_sw))
		else $error("module code in status wrong");
	chk_unmapped_zero: assert property (
		reg_rd && reg_addr > REG_CHAN |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_irq_off: assert property (
		ctl[CTL_IRQSRC +: 2] == IRQ_OFF && $past(ctl[CTL_IRQSRC +: 2]) == IRQ_OFF |-> !host_irq)
		else $error("interrupt raised while source is off");
	chk_idle_quiet: assert property (
		idle_cnt >= 4'h3 |-> !adc_start)
		else $error("conversion started while stopped");
	chk_chan_bound: assert property (
		adc_start |-> adc_chan <= chan_top)
		else $error("channel beyond top channel");
endmodule // aqs_seq_monitor

bind aqs_sequencer aqs_seq_monitor #(.CH_W(CH_W)) i_aqs_seq_monitor (
	.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .module_id_sw(module_id_sw),
	.adc_start(adc_start), .adc_chan(adc_chan), .dac_code(dac_code),
	.dac_is_threshold(dac_is_threshold), .synth_setting(synth_setting),
	.io_space(io_space), .host_irq(host_irq)
);

//--- verif/tb_adc_acquisition_sequencer.sv
// Self-checking bench of the acquisition sequencer
`timescale 1ns/100ps
module tb_adc_acquisition_sequencer
	import aqs_pkg::*;
();
	typedef struct packed {
		logic [15:0] ctl;
		logic [15:0] base;
		logic [3:0]  mod;
		logic        mk;
		logic [7:0]  n;
		logic [3:0]  nib;
	} aqs_frame_s;
	// Frames: control, code base, module, marker, length, expected top nibble
	aqs_frame_s rows [8] = '{
		'{16'h902B, 16'h0100, 4'h0, 1'b0, 8'h06, 4'h0},
		'{16'h142B, 16'h0800, 4'h0, 1'b0, 8'h02, 4'hF},
		'{16'h122B, 16'h1000, 4'hF, 1'b1, 8'h02, 4'h0},
		'{16'h106B, 16'h0100, 4'h0, 1'b0, 8'h04, 4'h0},
		'{16'h102D, 16'h0100, 4'h0, 1'b0, 8'h02, 4'h0},
		'{16'h1809, 16'h0100, 4'h0, 1'b0, 8'h02, 4'h0},
		'{16'h101F, 16'h0100, 4'h0, 1'b0, 8'h02, 4'h0},
		'{16'h122B, 16'h0100, 4'h0, 1'b1, 8'h02, 4'h8}};
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ext_trig = 1'b0;
	logic        marker = 1'b0;
	logic        xfer_done = 1'b0;
	logic [3:0]  sw = 4'h3;
	logic [15:0] base = 16'h0100;
	wire  [31:0] reg_rdata;
	wire  [15:0] adc_data;
	wire  [3:0]  adc_chan;
	wire  [11:0] dac_code;
	wire  [15:0] synth_setting;
	wire         xt10, xt20, adc_start, dac_is_threshold, io_space, host_irq;
	logic [31:0] rdv;
	logic [3:0]  dn;
	int          k;
	int          n_errors = 0;
	int          num_checks = 0;

	always #12.5 core_clk = ~core_clk;

	// Synthesizer and external clock borrow the crystal enables; comparator trips with the trigger
	aqs_sequencer #(.FIFO_DEPTH_P(16)) i_aqs_sequencer (
		.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .synth_tick(xt20),
		.xtal10_tick(xt10), .xtal20_tick(xt20), .ext_clk_tick(xt10), .comp_trip(ext_trig),
		.ext_trig(ext_trig), .marker(marker), .adc_data(adc_data), .module_id_sw(sw),
		.adc_start(adc_start), .adc_chan(adc_chan), .dac_code(dac_code),
		.dac_is_threshold(dac_is_threshold), .synth_setting(synth_setting),
		.xfer_done(xfer_done), .io_space(io_space), .host_irq(host_irq));
	aqs_conv_model i_aqs_conv_model (
		.core_clk(core_clk), .srst(srst), .adc_start(adc_start), .base(base),
		.adc_data(adc_data), .xtal10_tick(xt10), .xtal20_tick(xt20));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask

	task automatic trig();
		@(posedge core_clk);
		ext_trig <= 1'b1;
		@(posedge core_clk);
		ext_trig <= 1'b0;
	endtask

	task automatic starts(input int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(negedge core_clk);
			if (adc_start === 1'b1) n++;
		end
	endtask

	task automatic summarize();
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under ten thousand cycles
	initial begin
		#(25 * 20000);
		n_errors++;
		summarize();
	end

	initial begin
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(negedge core_clk);
		check("irq reset", host_irq, 0);
		check("dac reset", dac_code, 0);
		rd(REG_STATUS, rdv);
		check("status reset", rdv[11:0], 32'h308);
		rd(8'h24, rdv);
		check("unmapped", rdv, 0);
		rd(REG_FIFO, rdv);
		check("empty pop", rdv, 0);
		wr(REG_DAC, 32'hFFFF_F5A5);
		wr(REG_SYNTH, 32'h0000_A5C3);
		wr(REG_CTRL, 32'h0000_4800);
		repeat (2) @(negedge core_clk);
		check("dac", dac_code, 32'h5A5);
		check("synth", synth_setting, 32'hA5C3);
		check("io space", io_space, 1);
		check("threshold", dac_is_threshold, 1);
		wr(REG_CLKDIV, 32'h1);
		wr(REG_CHAN, 32'h3);
		// Triggered frames, one row each
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			sw     <= rows[i].mod;
			marker <= rows[i].mk;
			base   <= rows[i].base;
			wr(REG_CTRL, {16'h0, rows[i].ctl});
			wr(REG_COUNT, {24'h0, rows[i].n});
			rd(REG_STATUS, rdv);
			check("armed done", rdv[ST_DONE], 0);
			trig();
			starts(40 * rows[i].n, k);
			check("samples", k, rows[i].n);
			check("done irq", host_irq, 1);
			rd(REG_STATUS, rdv);
			check("done", rdv[ST_DONE], 1);
			for (int j = 0; j < rows[i].n / 2; j++) begin
				rd(REG_FIFO, rdv);
				dn = rdv[19:16] - rdv[3:0];
				check("order", dn, 4'h1);
				check("high", rdv[31:28], rows[i].nib);
				check("low", rdv[15:12], rows[i].nib);
			end
			rd(REG_STATUS, rdv);
			check("drained", rdv[ST_EMPTY], 1);
		end
		// Fill without reading, then drain across the half mark
		@(posedge core_clk);
		sw     <= 4'h0;
		marker <= 1'b0;
		wr(REG_CTRL, 32'h00A3);
		wr(REG_COUNT, 32'h1);
		trig();
		starts(120, k);
		rd(REG_STATUS, rdv);
		check("full", rdv[ST_FULL], 1);
		check("half", rdv[ST_HALF], 1);
		check("half irq", host_irq, 1);
		wr(REG_CTRL, 32'h0);
		repeat (2) rd(REG_FIFO, rdv);
		repeat (2) rd(REG_FIFO, rdv);
		rd(REG_STATUS, rdv);
		check("at half", rdv[ST_HALF], 1);
		rd(REG_FIFO, rdv);
		rd(REG_STATUS, rdv);
		check("below half", rdv[ST_HALF], 0);
		check("half irq off", host_irq, 0);
		// Transfer-done interrupt, cleared by reading status
		wr(REG_CTRL, 32'h2000);
		@(posedge core_clk);
		xfer_done <= 1'b1;
		@(posedge core_clk);
		xfer_done <= 1'b0;
		repeat (3) @(negedge core_clk);
		check("xfer irq", host_irq, 1);
		rd(REG_STATUS, rdv);
		check("xfer flag", rdv[ST_XFER], 1);
		rd(REG_STATUS, rdv);
		check("xfer clear", rdv[ST_XFER], 0);
		wr(REG_CTRL, 32'h3000);
		// Pretrigger: sampling runs before the trigger, count waits for it
		wr(REG_CTRL, 32'h112B);
		wr(REG_COUNT, 32'h2);
		starts(100, k);
		check("pre sampling", k != 0, 1);
		rd(REG_STATUS, rdv);
		check("pre waiting", rdv[ST_DONE], 0);
		rd(REG_CHAN, rdv);
		trig();
		starts(60, k);
		rd(REG_STATUS, rdv);
		check("post done", rdv[ST_DONE], 1);
		summarize();
	end
endmodule // tb_adc_acquisition_sequencer
